// File: bench/fpw_host.sv
// host model: axi4-lite master that programs the protection block
`timescale 1ns/1ps
`include "fpw_cfg.svh"
module fpw_host (
	input wire logic clk_in, // bus clock
	output logic [7:0] s_axi_awaddr, // write address
	output logic s_axi_awvalid, // write address valid
	input wire logic s_axi_awready, // write address ready
	output logic [31:0] s_axi_wdata, // write data
	output logic [3:0] s_axi_wstrb, // write strobes
	output logic s_axi_wvalid, // write data valid
	input wire logic s_axi_wready, // write data ready
	input wire logic [1:0] s_axi_bresp, // write response
	input wire logic s_axi_bvalid, // write response valid
	output logic s_axi_bready, // write response ready
	output logic [7:0] s_axi_araddr, // read address
	output logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [1:0] s_axi_rresp, // read response
	input wire logic s_axi_rvalid, // read data valid
	output logic s_axi_rready // read data ready
);
	// bus idle at time zero
	initial begin
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
	end
	////////////////////////////////////////
	// one write: address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge clk_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge clk_in);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	// one read: address held until taken, data taken with rvalid
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge clk_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge clk_in);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	// host drops a switch enable when a cell leaves its voltage window
	task automatic cell_limits(input logic uv, input logic ov);
		logic [31:0] c;
		logic [1:0] r;
		rd(`FPW_CTRL_OFS, c, r);
		if (uv) c[`FPW_CTRL_DSG] = 1'b0;
		if (ov) c[`FPW_CTRL_CHG] = 1'b0;
		wr(`FPW_CTRL_OFS, c, r);
	endtask
endmodule

// File: bench/tb_fpw_top.sv
// self-checking bench for the protection switch, bias and wake control block
`timescale 1ns/1ps
`include "fpw_cfg.svh"
module tb_fpw_top;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic sc_cmp_in = 1'b0;
	logic doc_cmp_in = 1'b0;
	logic coc_cmp_in = 1'b0;
	logic load_monitor_input_in = 1'b1;
	logic ovt_cmp_in = 1'b0;
	logic wake_pin_in = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, analog_monitor_sel_out;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic discharge_switch_drive_out, charge_switch_drive_out, load_monitor_en_out;
	logic thermistor_bias_output_out, wake_event_out, irq_out;
	logic [31:0] rv;
	logic [11:0] row_ctrl [6];
	logic [7:0] row_exp [6];
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	int n_wake = 0;
	int n0;

	fpw_top DUT (.*);
	fpw_host host (.*);

	always #20 clk_in = ~clk_in;
	////////////////////////////////////////
	// cycle limit and wake pulse count
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (wake_event_out === 1'b1) n_wake <= n_wake + 1;
		if (cycles == 20000) begin
			failures++;
			stop_test();
		end
	end
	task automatic chk_bit(input logic got, input logic exp, input string m);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t %s got %h", $time, m, got);
		end
	endtask
	// masked register read compare
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		host.rd(a, rv, rr);
		chk_word(rv & m, e, "register read");
	endtask
	// let synchronisers and registered outputs land
	task automatic settle();
		repeat (6) @(posedge clk_in);
		#1;
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		row_ctrl = '{12'h003, 12'h508, 12'h210, 12'hf01, 12'h002, 12'h000};
		row_exp = '{8'h03, 8'h58, 8'h28, 8'hf1, 8'h02, 8'h00};
		repeat (4) @(posedge clk_in);
		nrst_in <= 1'b1;
		settle();
		chk_bit(discharge_switch_drive_out, 1'b0, "discharge at reset");
		chk_bit(charge_switch_drive_out, 1'b0, "charge at reset");
		chk_bit(thermistor_bias_output_out, 1'b0, "bias at reset");
		chk_bit(irq_out, 1'b0, "irq at reset");
		rchk(`FPW_CTRL_OFS, 32'hfff, 32'h0);
		rchk(`FPW_MASK_OFS, 32'hf, 32'h0);
		$display("test reset done");
		// control rows: switches, bias and channel select
		for (int i = 0; i < 6; i++) begin
			host.wr(`FPW_CTRL_OFS, {20'h0, row_ctrl[i]}, rr);
			settle();
			chk_word({24'h0, analog_monitor_sel_out, thermistor_bias_output_out, load_monitor_en_out,
				charge_switch_drive_out, discharge_switch_drive_out}, {24'h0, row_exp[i]}, "outputs");
			rchk(`FPW_CTRL_OFS, 32'hf0f, {20'h0, row_ctrl[i] & 12'hf0f});
		end
		$display("test control table done");
		// unmapped address refused
		host.wr(8'h10, 32'h3, rr);
		chk_word({30'h0, rr}, {30'h0, `FPW_RESP_SLVERR}, "unmapped write");
		host.wr(8'h06, 32'h3, rr);
		chk_word({30'h0, rr}, {30'h0, `FPW_RESP_SLVERR}, "unaligned write");
		host.rd(8'h10, rv, rr);
		chk_word({30'h0, rr}, {30'h0, `FPW_RESP_SLVERR}, "unmapped read");
		chk_word(rv, 32'h0, "unmapped data");
		rchk(`FPW_CTRL_OFS, 32'hfff, 32'h0);
		$display("test unmapped done");
		// short circuit, discharge and charge overcurrent, then load release
		for (int k = 0; k < 3; k++) begin
			host.wr(`FPW_CTRL_OFS, 32'h3, rr);
			settle();
			@(posedge clk_in);
			{coc_cmp_in, doc_cmp_in, sc_cmp_in} <= 3'h1 << k;
			settle();
			chk_bit(k == 2 ? charge_switch_drive_out : discharge_switch_drive_out, 1'b0, "forced off");
			chk_bit(thermistor_bias_output_out, 1'b1, "bias on fault");
			chk_bit(irq_out, 1'b1, "fault irq");
			@(posedge clk_in);
			{coc_cmp_in, doc_cmp_in, sc_cmp_in} <= 3'h0;
			host.wr(`FPW_CTRL_OFS, 32'h3, rr);
			settle();
			chk_bit(k == 2 ? charge_switch_drive_out : discharge_switch_drive_out, 1'b0, "held off");
			rchk(`FPW_STAT_OFS, 32'h8 | (32'h1 << k), 32'h8 | (32'h1 << k));
			host.wr(`FPW_CTRL_OFS, 32'h4, rr);
			settle();
			chk_bit(load_monitor_en_out, 1'b1, "load monitor enable");
			@(posedge clk_in);
			load_monitor_input_in <= 1'b0;
			settle();
			rchk(`FPW_STAT_OFS, 32'h8, 32'h0);
			rchk(`FPW_IRQ_OFS, 32'h2, 32'h2);
			load_monitor_input_in <= 1'b1;
			host.wr(`FPW_STAT_OFS, 32'h1 << k, rr);
			host.wr(`FPW_IRQ_OFS, 32'hf, rr);
			host.wr(`FPW_CTRL_OFS, 32'h0, rr);
			settle();
			rchk(`FPW_STAT_OFS, 32'h7, 32'h0);
			chk_bit(thermistor_bias_output_out, 1'b0, "bias after clear");
			chk_bit(irq_out, 1'b0, "irq cleared");
			$display("test fault %0d done", k);
		end
		// over temperature with interrupt masking
		host.wr(`FPW_MASK_OFS, 32'h1, rr);
		@(posedge clk_in);
		ovt_cmp_in <= 1'b1;
		settle();
		rchk(`FPW_STAT_OFS, 32'h20, 32'h20);
		chk_bit(irq_out, 1'b1, "unmasked irq");
		host.wr(`FPW_MASK_OFS, 32'h8, rr);
		settle();
		chk_bit(irq_out, 1'b0, "masked irq");
		rchk(`FPW_IRQ_OFS, 32'hf, 32'h8);
		ovt_cmp_in <= 1'b0;
		host.wr(`FPW_IRQ_OFS, 32'h8, rr);
		host.wr(`FPW_STAT_OFS, 32'h20, rr);
		host.wr(`FPW_MASK_OFS, 32'h0, rr);
		rchk(`FPW_STAT_OFS, 32'h20, 32'h0);
		$display("test over temperature done");
		// host reaction to cell voltage limits
		host.wr(`FPW_CTRL_OFS, 32'h3, rr);
		host.cell_limits(1'b1, 1'b0);
		settle();
		chk_bit(discharge_switch_drive_out, 1'b0, "undervoltage off");
		chk_bit(charge_switch_drive_out, 1'b1, "charge kept");
		host.cell_limits(1'b0, 1'b1);
		settle();
		chk_bit(charge_switch_drive_out, 1'b0, "overvoltage off");
		$display("test cell limits done");
		// wake on rising, not on level, then on falling
		host.wr(`FPW_CTRL_OFS, 32'h60, rr);
		settle();
		rchk(`FPW_STAT_OFS, 32'h50, 32'h40);
		n0 = n_wake;
		@(posedge clk_in);
		wake_pin_in <= 1'b1;
		settle();
		chk_word(n_wake - n0, 32'h1, "rising wake");
		rchk(`FPW_STAT_OFS, 32'h50, 32'h10);
		host.wr(`FPW_CTRL_OFS, 32'h60, rr);
		settle();
		chk_word(n_wake - n0, 32'h1, "level no wake");
		host.wr(`FPW_CTRL_OFS, 32'h40, rr);
		settle();
		rchk(`FPW_STAT_OFS, 32'h10, 32'h0);
		@(posedge clk_in);
		wake_pin_in <= 1'b0;
		settle();
		chk_word(n_wake - n0, 32'h2, "falling wake");
		rchk(`FPW_STAT_OFS, 32'h50, 32'h10);
		rchk(`FPW_IRQ_OFS, 32'h4, 32'h4);
		$display("test wake done");
		stop_test();
	end
endmodule

// File: verilog/fpw_cfg.svh
// register offsets, field positions and reset values of the protection control block
`ifndef FPW_CFG_SVH
`define FPW_CFG_SVH
`define FPW_CTRL_OFS 8'h00
`define FPW_STAT_OFS 8'h04
`define FPW_IRQ_OFS 8'h08
`define FPW_MASK_OFS 8'h0c
`define FPW_CTRL_RST 32'h0000_0000
`define FPW_MASK_RST 4'h0
`define FPW_CTRL_DSG 0
`define FPW_CTRL_CHG 1
`define FPW_CTRL_LDMON 2
`define FPW_CTRL_TBON 3
`define FPW_CTRL_TMEAS 4
`define FPW_CTRL_WPOL 5
`define FPW_CTRL_SLEEP 6
`define FPW_CTRL_CHAN_LO 8
`define FPW_ST_SC 0
`define FPW_ST_DOC 1
`define FPW_ST_COC 2
`define FPW_ST_LDF 3
`define FPW_ST_WAKE 4
`define FPW_ST_OVT 5
`define FPW_ST_ASLEEP 6
`define FPW_EV_FAULT 0
`define FPW_EV_LDREL 1
`define FPW_EV_WAKE 2
`define FPW_EV_OVT 3
`define FPW_RESP_OKAY 2'b00
`define FPW_RESP_SLVERR 2'b10
`endif

// File: verilog/fpw_pkg.sv
// types shared by the protection control block
package fpw_pkg;
	typedef struct packed {
		logic short_circuit;
		logic discharge_overcurrent;
		logic charge_overcurrent;
		logic load_above;
		logic ovt_cmp;
		logic wake_pin;
	} fpw_sense_s;
	typedef struct packed {
		logic [3:0] chan;
		logic sleep;
		logic wake_pol;
		logic tmeas;
		logic tbias_on;
		logic ldmon_en;
		logic charge_en;
		logic discharge_en;
	} fpw_ctrl_s;
	typedef enum logic [1:0] {FPW_IDLE, FPW_WDATA, FPW_WRESP} fpw_wr_e;
endpackage

// File: verilog/fpw_top.sv
// protection switch, thermistor bias and wake control with an axi4-lite register slave
`timescale 1ns/1ps
`include "fpw_cfg.svh"
module fpw_top import fpw_pkg::*; (
	input wire logic clk_in, // 25 mhz clock
	input wire logic nrst_in, // async reset, active low
	input wire logic sc_cmp_in, // short circuit comparator
	input wire logic doc_cmp_in, // discharge overcurrent comparator
	input wire logic coc_cmp_in, // charge overcurrent comparator
	input wire logic load_monitor_input_in, // load monitor above threshold
	input wire logic ovt_cmp_in, // thermistor input below bias/13
	input wire logic wake_pin_in, // wake pin above threshold
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic discharge_switch_drive_out, // discharge switch gate drive
	output logic charge_switch_drive_out, // charge switch gate drive
	output logic load_monitor_en_out, // load monitor resistor to ground
	output logic thermistor_bias_output_out, // thermistor bias switch
	output logic [3:0] analog_monitor_sel_out, // analog monitor channel select
	output logic wake_event_out, // one-cycle wake pulse while asleep
	output logic irq_out // level interrupt
);
////////////////////////////////////////////////////////////////////////////////
	// reset release through two flip-flops
	logic rst_m, rst_q;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			{rst_q, rst_m} <= 2'b00;
		end else begin
			{rst_q, rst_m} <= {rst_m, 1'b1};
		end
	end
	wire rst_n = rst_q;
////////////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for every pin input
	fpw_sense_s sn_m, sn_q, pin_raw;
	assign pin_raw = '{sc_cmp_in, doc_cmp_in, coc_cmp_in, load_monitor_input_in, ovt_cmp_in, wake_pin_in};
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			{sn_q, sn_m} <= '0;
		end else begin
			{sn_q, sn_m} <= {sn_m, pin_raw};
		end
	end
////////////////////////////////////////////////////////////////////////////////
	// state declarations
	fpw_ctrl_s ctrl, next_ctrl;
	logic short_circuit_flag, next_short_circuit_flag;
	logic discharge_overcurrent_flag, next_discharge_overcurrent_flag;
	logic charge_overcurrent_flag, next_charge_overcurrent_flag;
	logic load_fail_flag, next_load_fail_flag;
	logic ovt_flag, next_ovt_flag;
	logic wake_prev, next_wake_prev;
	logic asleep, next_asleep;
	logic [3:0] irq_stat, next_irq_stat;
	logic [3:0] irq_mask, next_irq_mask;
	logic dsg_drv, next_dsg_drv, chg_drv, next_chg_drv, tbias, next_tbias;
	logic wake_pulse, next_wake_pulse, irq, next_irq, ldmon, next_ldmon;
	logic [3:0] chan_q, next_chan_q;
	fpw_wr_e wst, next_wst;
	logic [7:0] waddr, next_waddr;
	logic [31:0] wdat, next_wdat;
	logic [3:0] wstb, next_wstb;
	logic aw_got, next_aw_got, w_got, next_w_got;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic wr_fire;
	logic [31:0] wmask, ctrl_w, stat_r, ctrl_r;
	logic wake_level, wake_edge, fault_any;
	logic [2:0] rdy, next_rdy;
////////////////////////////////////////////////////////////////////////////////
	// axi write channel: take address and data in either order, then respond
	always_comb begin
		next_wst = wst;
		next_waddr = waddr;
		next_wdat = wdat;
		next_wstb = wstb;
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_bvalid = bvalid;
		next_bresp = bresp;
		wr_fire = 1'b0;
		case (wst)
			FPW_IDLE, FPW_WDATA: begin
				if (s_axi_awvalid && !aw_got) begin
					next_aw_got = 1'b1;
					next_waddr = s_axi_awaddr;
				end
				if (s_axi_wvalid && !w_got) begin
					next_w_got = 1'b1;
					next_wdat = s_axi_wdata;
					next_wstb = s_axi_wstrb;
				end
				next_wst = FPW_WDATA;
				if (aw_got && w_got) begin
					wr_fire = 1'b1;
					next_aw_got = 1'b0;
					next_w_got = 1'b0;
					next_bvalid = 1'b1;
					next_bresp = (waddr[7:4] == 4'h0 && waddr[1:0] == 2'b00) ? `FPW_RESP_OKAY : `FPW_RESP_SLVERR;
					next_wst = FPW_WRESP;
				end
			end
			FPW_WRESP: begin
				if (s_axi_bready) begin
					next_bvalid = 1'b0;
					next_wst = FPW_IDLE;
				end
			end
			default: next_wst = FPW_IDLE;
		endcase
	end
	// byte-lane mask from strobes
	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign wmask[8*i+:8] = {8{wstb[i]}};
	end
////////////////////////////////////////////////////////////////////////////////
	// register read mux
	assign ctrl_r = {20'h0, ctrl.chan, 1'b0, ctrl.sleep, ctrl.wake_pol, ctrl.tmeas, ctrl.tbias_on, ctrl.ldmon_en,
		ctrl.charge_en, ctrl.discharge_en};
	assign stat_r = {25'h0, asleep, ovt_flag, wake_level, load_fail_flag, charge_overcurrent_flag,
		discharge_overcurrent_flag, short_circuit_flag};
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end else if (!rvalid && s_axi_arvalid) begin
			next_rvalid = 1'b1;
			next_rresp = `FPW_RESP_OKAY;
			case (s_axi_araddr)
				`FPW_CTRL_OFS: next_rdata = ctrl_r;
				`FPW_STAT_OFS: next_rdata = stat_r;
				`FPW_IRQ_OFS: next_rdata = {28'h0, irq_stat};
				`FPW_MASK_OFS: next_rdata = {28'h0, irq_mask};
				default: begin
					next_rdata = 32'h0;
					next_rresp = `FPW_RESP_SLVERR;
				end
			endcase
		end
	end
////////////////////////////////////////////////////////////////////////////////
	// protection, wake and bias logic
	always_comb begin
		ctrl_w = (ctrl_r & ~wmask) | (wdat & wmask);
		next_ctrl = ctrl;
		if (wr_fire && waddr == `FPW_CTRL_OFS) begin
			next_ctrl.discharge_en = ctrl_w[`FPW_CTRL_DSG];
			next_ctrl.charge_en = ctrl_w[`FPW_CTRL_CHG];
			next_ctrl.ldmon_en = ctrl_w[`FPW_CTRL_LDMON];
			next_ctrl.tbias_on = ctrl_w[`FPW_CTRL_TBON];
			next_ctrl.tmeas = ctrl_w[`FPW_CTRL_TMEAS];
			next_ctrl.wake_pol = ctrl_w[`FPW_CTRL_WPOL];
			next_ctrl.sleep = ctrl_w[`FPW_CTRL_SLEEP];
			next_ctrl.chan = ctrl_w[`FPW_CTRL_CHAN_LO+:4];
		end
		// hardware set wins over a host clear
		next_short_circuit_flag = short_circuit_flag;
		next_discharge_overcurrent_flag = discharge_overcurrent_flag;
		next_charge_overcurrent_flag = charge_overcurrent_flag;
		next_ovt_flag = ovt_flag;
		if (wr_fire && waddr == `FPW_STAT_OFS && wstb[0]) begin
			if (wdat[`FPW_ST_SC]) next_short_circuit_flag = 1'b0;
			if (wdat[`FPW_ST_DOC]) next_discharge_overcurrent_flag = 1'b0;
			if (wdat[`FPW_ST_COC]) next_charge_overcurrent_flag = 1'b0;
			if (wdat[`FPW_ST_OVT]) next_ovt_flag = 1'b0;
		end
		if (sn_q.short_circuit) next_short_circuit_flag = 1'b1;
		if (sn_q.discharge_overcurrent) next_discharge_overcurrent_flag = 1'b1;
		if (sn_q.charge_overcurrent) next_charge_overcurrent_flag = 1'b1;
		if (sn_q.ovt_cmp) next_ovt_flag = 1'b1;
		fault_any = next_short_circuit_flag | next_discharge_overcurrent_flag | next_charge_overcurrent_flag;
		// forced off on fault: host bit cleared so the host must re-enable
		if (next_short_circuit_flag || next_discharge_overcurrent_flag) next_ctrl.discharge_en = 1'b0;
		if (next_charge_overcurrent_flag) next_ctrl.charge_en = 1'b0;
		// load fail set by fault, cleared by load release while monitoring
		next_load_fail_flag = load_fail_flag;
		if (load_fail_flag && ctrl.ldmon_en && !sn_q.load_above) next_load_fail_flag = 1'b0;
		if (sn_q.short_circuit || sn_q.discharge_overcurrent || sn_q.charge_overcurrent) next_load_fail_flag = 1'b1;
		next_dsg_drv = next_ctrl.discharge_en && !next_load_fail_flag;
		next_chg_drv = next_ctrl.charge_en && !next_load_fail_flag;
		next_ldmon = next_ctrl.ldmon_en && load_fail_flag;
		next_tbias = next_ctrl.tmeas | next_ctrl.tbias_on | fault_any;
		next_chan_q = next_ctrl.chan;
		// wake level and edge
		wake_level = ctrl.wake_pol ? sn_q.wake_pin : !sn_q.wake_pin;
		next_wake_prev = sn_q.wake_pin;
		wake_edge = ctrl.wake_pol ? (sn_q.wake_pin && !wake_prev) : (!sn_q.wake_pin && wake_prev);
		next_asleep = asleep;
		if (next_ctrl.sleep && !ctrl.sleep) next_asleep = 1'b1;
		if (asleep && wake_edge) begin
			next_asleep = 1'b0;
			next_ctrl.sleep = 1'b0;
		end
		next_wake_pulse = asleep && wake_edge;
		// interrupt status: set wins over write-one clear
		next_irq_stat = irq_stat;
		if (wr_fire && waddr == `FPW_IRQ_OFS && wstb[0]) next_irq_stat = irq_stat & ~wdat[3:0];
		if (fault_any && !(short_circuit_flag | discharge_overcurrent_flag | charge_overcurrent_flag))
			next_irq_stat[`FPW_EV_FAULT] = 1'b1;
		if (load_fail_flag && !next_load_fail_flag) next_irq_stat[`FPW_EV_LDREL] = 1'b1;
		if (wake_edge) next_irq_stat[`FPW_EV_WAKE] = 1'b1;
		if (sn_q.ovt_cmp && !ovt_flag) next_irq_stat[`FPW_EV_OVT] = 1'b1;
		next_irq_mask = irq_mask;
		if (wr_fire && waddr == `FPW_MASK_OFS && wstb[0]) next_irq_mask = wdat[3:0];
		next_irq = |(next_irq_stat & ~next_irq_mask);
	end
////////////////////////////////////////////////////////////////////////////////
	// state registers
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= fpw_ctrl_s'(11'(`FPW_CTRL_RST));
			short_circuit_flag <= 1'b0;
			discharge_overcurrent_flag <= 1'b0;
			charge_overcurrent_flag <= 1'b0;
			load_fail_flag <= 1'b0;
			ovt_flag <= 1'b0;
			wake_prev <= 1'b0;
			asleep <= 1'b0;
			irq_stat <= 4'h0;
			irq_mask <= `FPW_MASK_RST;
			dsg_drv <= 1'b0;
			chg_drv <= 1'b0;
			tbias <= 1'b0;
			ldmon <= 1'b0;
			chan_q <= 4'h0;
			wake_pulse <= 1'b0;
			irq <= 1'b0;
			wst <= FPW_IDLE;
			waddr <= 8'h00;
			wdat <= 32'h0;
			wstb <= 4'h0;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'b00;
			rvalid <= 1'b0;
			rresp <= 2'b00;
			rdata <= 32'h0;
			rdy <= 3'h0;
		end else begin
			ctrl <= next_ctrl;
			short_circuit_flag <= next_short_circuit_flag;
			discharge_overcurrent_flag <= next_discharge_overcurrent_flag;
			charge_overcurrent_flag <= next_charge_overcurrent_flag;
			load_fail_flag <= next_load_fail_flag;
			ovt_flag <= next_ovt_flag;
			wake_prev <= next_wake_prev;
			asleep <= next_asleep;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			dsg_drv <= next_dsg_drv;
			chg_drv <= next_chg_drv;
			tbias <= next_tbias;
			ldmon <= next_ldmon;
			chan_q <= next_chan_q;
			wake_pulse <= next_wake_pulse;
			irq <= next_irq;
			wst <= next_wst;
			waddr <= next_waddr;
			wdat <= next_wdat;
			wstb <= next_wstb;
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			rdy <= next_rdy;
		end
	end
	// outputs straight from flip-flops; ready flags are registered from the next state
	assign next_rdy = {(next_wst != FPW_WRESP) && !next_aw_got, (next_wst != FPW_WRESP) && !next_w_got, !next_rvalid};
	assign s_axi_awready = rdy[2];
	assign s_axi_wready = rdy[1];
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_arready = rdy[0];
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign discharge_switch_drive_out = dsg_drv;
	assign charge_switch_drive_out = chg_drv;
	assign load_monitor_en_out = ldmon;
	assign thermistor_bias_output_out = tbias;
	assign analog_monitor_sel_out = chan_q;
	assign wake_event_out = wake_pulse;
	assign irq_out = irq;
////////////////////////////////////////////////////////////////////////////////
	// checks
	a_dsg_needs_host: assert property (@(posedge clk_in) disable iff (!rst_n) $rose(dsg_drv) |-> $past(ctrl.discharge_en) || ctrl.discharge_en) else $error("discharge drive on without host bit");
	a_dsg_fault_off: assert property (@(posedge clk_in) disable iff (!rst_n) sn_q.short_circuit |=> !dsg_drv) else $error("discharge drive on during short circuit");
	a_chg_needs_host: assert property (@(posedge clk_in) disable iff (!rst_n) chg_drv |-> ctrl.charge_en) else $error("charge drive on without host bit");
	a_chg_fault_off: assert property (@(posedge clk_in) disable iff (!rst_n) sn_q.charge_overcurrent |=> !chg_drv && !ctrl.charge_en) else $error("charge drive on during overcurrent");
	a_bias_follow: assert property (@(posedge clk_in) disable iff (!rst_n) ctrl.tbias_on |-> tbias) else $error("bias not held on");
	a_bias_fault: assert property (@(posedge clk_in) disable iff (!rst_n) short_circuit_flag |-> tbias) else $error("bias off with fault flag");
	a_bias_idle: assert property (@(posedge clk_in) disable iff (!rst_n) !ctrl.tmeas && !ctrl.tbias_on && !short_circuit_flag && !discharge_overcurrent_flag && !charge_overcurrent_flag |-> !tbias) else $error("bias on while idle");
	a_flag_sticky: assert property (@(posedge clk_in) disable iff (!rst_n) short_circuit_flag && !wr_fire |=> short_circuit_flag) else $error("fault flag lost without write");
	a_wake_edge: assert property (@(posedge clk_in) disable iff (!rst_n) asleep && ctrl.wake_pol && sn_q.wake_pin && !wake_prev |=> wake_pulse && !asleep) else $error("missed rising wake");
	a_ldf_release: assert property (@(posedge clk_in) disable iff (!rst_n) load_fail_flag && ctrl.ldmon_en && !sn_q.load_above && !sn_q.short_circuit && !sn_q.discharge_overcurrent && !sn_q.charge_overcurrent |=> !load_fail_flag) else $error("load fail not cleared");
endmodule
